// >>> hdl/fiqd_core.sv
// How it works
// - Non-memory float instruction reaches the FPU queue two cycles after detection.
// - Integer side keeps issuing while the FPU executes in parallel.
// - Later float instructions wait in a queue of at most four entries.
// - Exception with instructions still queued saves state for recovery.
// - Protected mode operand violation faults 13; a lone stack limit violation faults 12.
// - Stack top comes from the top pointer field of the status register.
// - Register field n selects the register n places from the stack top.
// - Memory formats: int 16/32/64, real 32/64/80, 18-digit packed BCD.
// - D9 F0 sets stack top to two to its power minus one, 92-108 clocks.
// - D9 E1 makes the stack top absolute in 2 clocks.
// - D9 E0 inverts the stack top sign in 2 clocks.
// - DE register form adds stack top into ST(n) then pops.
// - Waiting clear-exceptions runs after pending work, 5 clocks.
// - Non-waiting clear-exceptions clears flags in 3 clocks.
// - DA moves copy ST(n) to top if CF, ZF, CF or ZF, PF set.
// - DB moves copy if CF clear, ZF clear, both clear, or PF clear.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module fiqd_core #(
	parameter int unsigned DEPTH = 4
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        iu_valid,
	input  wire logic [7:0]  iu_op,
	input  wire logic [7:0]  iu_modrm,
	input  wire logic        iu_wait_prefix,
	input  wire logic        iu_has_mem,
	input  wire logic        iu_cf,
	input  wire logic        iu_zf,
	input  wire logic        iu_pf,
	input  wire logic        prot_mode,
	input  wire logic        seg_limit_viol,
	input  wire logic        access_viol,
	input  wire logic        stack_limit_viol,
	output var  logic        iu_ready,
	output var  logic        fault_valid,
	output var  logic [7:0]  fault_vector,
	output var  logic        mem_req,
	output var  logic [2:0]  mem_fmt,
	input  wire logic        mem_valid,
	input  wire logic [79:0] mem_data,
	output var  logic        arith_start,
	output var  logic [1:0]  arith_kind,
	output var  logic [2:0]  arith_fmt,
	output var  logic [79:0] arith_a,
	output var  logic [79:0] arith_b,
	input  wire logic        arith_done,
	input  wire logic [79:0] arith_result,
	input  wire logic [5:0]  arith_exc,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// ----------------------------------------
	// State
	// ----------------------------------------
	fiqd_pkg::fiqd_hs_t  hs;
	fiqd_pkg::fiqd_ex_t  ex_state;
	fiqd_pkg::fiqd_act_t ex_act;
	logic [7:0]  h_op, h_modrm;
	logic [2:0]  h_flags;
	logic        h_wait;
	logic        hs_cnt;
	logic [7:0]  q_op [DEPTH];
	logic [7:0]  q_modrm [DEPTH];
	logic [2:0]  q_flags [DEPTH];
	logic        q_wait [DEPTH];
	logic [79:0] q_mem [DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr;
	logic [CW-1:0] q_cnt;
	logic [79:0] st [8];
	logic [2:0]  top, ex_dst, ex_src, sel;
	logic [fiqd_pkg::CYC_W-1:0] ex_cnt;
	logic        ex_ar, ex_got, ex_pop, saved, unsup;
	logic [15:0] ex_op;
	logic [18:0] saved_word;
	logic [5:0]  exc;
	logic [79:0] ar_res;

	// Format of a memory operand from opcode and reg field
	function automatic logic [2:0] fmt_of(input logic [7:0] op,
		input logic [2:0] rf);
		case (op)
			fiqd_pkg::OP_D8, fiqd_pkg::OP_D9: fmt_of = fiqd_pkg::FMT_REAL32;
			fiqd_pkg::OP_DC, fiqd_pkg::OP_DD: fmt_of = fiqd_pkg::FMT_REAL64;
			fiqd_pkg::OP_DA: fmt_of = fiqd_pkg::FMT_INT32;
			fiqd_pkg::OP_DB: fmt_of = (rf == 3'h5) ? fiqd_pkg::FMT_REAL80
				: fiqd_pkg::FMT_INT32;
			fiqd_pkg::OP_DE: fmt_of = fiqd_pkg::FMT_INT16;
			fiqd_pkg::OP_DF: fmt_of = (rf == 3'h4) ? fiqd_pkg::FMT_BCD
				: (rf == 3'h5) ? fiqd_pkg::FMT_INT64 : fiqd_pkg::FMT_INT16;
			default: fmt_of = fiqd_pkg::FMT_NONE;
		endcase
	endfunction

	// ----------------------------------------
	// Hand-over from the integer side
	// ----------------------------------------
	wire accept  = iu_valid && iu_ready;
	wire viol    = prot_mode && (seg_limit_viol || access_viol
		|| stack_limit_viol);
	wire go_busy = accept && !(iu_has_mem && viol);
	wire push    = (hs == fiqd_pkg::HS_DLY && !hs_cnt)
		|| (hs == fiqd_pkg::HS_MEM && mem_valid);
	wire pop     = ex_state == fiqd_pkg::EX_IDLE && q_cnt != '0;
	wire next_idle = (hs == fiqd_pkg::HS_IDLE && !go_busy) || push;
	wire [CW-1:0] next_cnt = CW'(q_cnt + CW'(push) - CW'(pop));

	// Hand-over sequencer and fault check
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hs <= fiqd_pkg::HS_IDLE;
			hs_cnt <= 1'b0;
			mem_req <= 1'b0;
			mem_fmt <= fiqd_pkg::FMT_NONE;
			fault_valid <= 1'b0;
			fault_vector <= 8'h00;
			h_op <= 8'h00;
			h_modrm <= 8'h00;
			h_flags <= 3'h0;
			h_wait <= 1'b0;
		end else begin
			fault_valid <= 1'b0;
			case (hs)
				fiqd_pkg::HS_IDLE: if (accept) begin
					h_op <= iu_op;
					h_modrm <= iu_modrm;
					h_flags <= {iu_pf, iu_zf, iu_cf};
					h_wait <= iu_wait_prefix;
					if (iu_has_mem && viol) begin
						fault_valid <= 1'b1;
						fault_vector <= (stack_limit_viol && !seg_limit_viol
							&& !access_viol) ? fiqd_pkg::FAULT_SS
							: fiqd_pkg::FAULT_GP;
					end else if (iu_has_mem) begin
						hs <= fiqd_pkg::HS_MEM;
						mem_req <= 1'b1;
						mem_fmt <= fmt_of(iu_op, iu_modrm[5:3]);
					end else begin
						hs <= fiqd_pkg::HS_DLY;
						hs_cnt <= 1'(fiqd_pkg::HANDOVER_CYC - 1);
					end
				end
				fiqd_pkg::HS_DLY: begin
					if (!hs_cnt) hs <= fiqd_pkg::HS_IDLE;
					hs_cnt <= 1'b0;
				end
				fiqd_pkg::HS_MEM: if (mem_valid) begin
					mem_req <= 1'b0;
					hs <= fiqd_pkg::HS_IDLE;
				end
				default: hs <= fiqd_pkg::HS_IDLE;
			endcase
		end
	end

	// Ready to integer side; low only while busy or queue full
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) iu_ready <= 1'b0;
		else iu_ready <= next_idle && (next_cnt < CW'(DEPTH));
	end

	// ----------------------------------------
	// Instruction queue
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_q
			always_ff @(posedge sys_clk) begin
				if (push && wr_ptr == PW'(g)) begin
					q_op[g] <= h_op;
					q_modrm[g] <= h_modrm;
					q_flags[g] <= h_flags;
					q_wait[g] <= h_wait;
					q_mem[g] <= mem_data;
				end
			end
		end
	endgenerate

	// Queue pointers and occupancy
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			q_cnt <= '0;
		end else begin
			if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1);
			if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1);
			q_cnt <= next_cnt;
		end
	end

	// ----------------------------------------
	// Decode of the queue head
	// ----------------------------------------
	wire [7:0] hop = q_op[rd_ptr];
	wire [7:0] hm  = q_modrm[rd_ptr];
	wire [2:0] hf  = q_flags[rd_ptr];
	wire [2:0] rf  = hm[5:3];
	wire is_reg    = hm[7:6] == 2'h3;
	wire [2:0] stn = 3'(top + hm[2:0]);
	wire op_d9 = hop == fiqd_pkg::OP_D9;
	wire op_da = hop == fiqd_pkg::OP_DA;
	wire op_db = hop == fiqd_pkg::OP_DB;
	wire op_dc = hop == fiqd_pkg::OP_DC;
	wire op_de = hop == fiqd_pkg::OP_DE;
	wire op_d8 = hop == fiqd_pkg::OP_D8;
	wire d_pow2 = op_d9 && hm == fiqd_pkg::MR_POW2;
	wire d_abs  = op_d9 && hm == fiqd_pkg::MR_ABS;
	wire d_chs  = op_d9 && hm == fiqd_pkg::MR_CHS;
	wire d_clr  = op_db && hm == fiqd_pkg::MR_CLEX;
	wire d_faddr = (op_d8 || op_dc || op_de) && is_reg && rf == 3'h0;
	wire d_faddm = (op_d8 || op_dc) && !is_reg && rf == 3'h0;
	wire d_iadd  = (op_da || op_de) && !is_reg && rf == 3'h0;
	wire d_cmov  = (op_da || op_db) && is_reg && !rf[2];
	// DB forms test the negation of the DA conditions
	wire cond_raw = (rf[1:0] == 2'h0) ? hf[0]
		: (rf[1:0] == 2'h1) ? hf[1]
		: (rf[1:0] == 2'h2) ? (hf[0] || hf[1]) : hf[2];
	wire cmov_ok = cond_raw ^ op_db;
	wire d_arith = d_pow2 || d_faddr || d_faddm || d_iadd;
	wire d_known = d_arith || d_abs || d_chs || d_clr || d_cmov;
	wire fiqd_pkg::fiqd_act_t d_act = d_arith ? fiqd_pkg::ACT_ARITH
		: d_abs ? fiqd_pkg::ACT_ABS : d_chs ? fiqd_pkg::ACT_CHS
		: d_clr ? fiqd_pkg::ACT_CLR
		: (d_cmov && cmov_ok) ? fiqd_pkg::ACT_CMOV : fiqd_pkg::ACT_NONE;
	wire [fiqd_pkg::CYC_W-1:0] d_cyc = fiqd_pkg::CYC_W'(
		d_pow2 ? fiqd_pkg::CYC_POW2_MIN
		: (d_faddr || d_faddm) ? fiqd_pkg::CYC_FLOAT_ADD_OP_MIN
		: d_iadd ? fiqd_pkg::CYC_IADD_MIN
		: d_abs ? fiqd_pkg::CYC_ABS : d_chs ? fiqd_pkg::CYC_CHS
		: d_clr ? (q_wait[rd_ptr] ? fiqd_pkg::CYC_CLR_WAIT
			: fiqd_pkg::CYC_CLR_NOW)
		: d_cmov ? fiqd_pkg::CYC_CMOV : fiqd_pkg::CYC_UNSUP);
	wire [2:0] d_dst = (d_faddr && (op_dc || op_de)) ? stn : top;
	wire d_pop = d_faddr && op_de;
	wire fiqd_pkg::fiqd_ar_t d_ar = d_pow2 ? fiqd_pkg::AR_POW2
		: d_iadd ? fiqd_pkg::AR_IADD : fiqd_pkg::AR_FLOAT_ADD_OP;

	// ----------------------------------------
	// Execution
	// ----------------------------------------
	wire ar_ok  = !ex_ar || ex_got || arith_done;
	wire commit = ex_state == fiqd_pkg::EX_RUN && ex_cnt == '0 && ar_ok;
	wire [79:0] ar_val = arith_done ? arith_result : ar_res;
	wire exc_evt = arith_done && arith_exc != 6'h00;
	wire busy = ex_state != fiqd_pkg::EX_IDLE || q_cnt != '0
		|| hs != fiqd_pkg::HS_IDLE;

	// Execution sequencer; holds each op its documented clock count
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ex_state <= fiqd_pkg::EX_IDLE;
			ex_act <= fiqd_pkg::ACT_NONE;
			ex_cnt <= '0;
			ex_dst <= 3'h0;
			ex_src <= 3'h0;
			ex_pop <= 1'b0;
			ex_ar <= 1'b0;
			ex_got <= 1'b0;
			ex_op <= 16'h0000;
			ar_res <= 80'h0;
		end else begin
			if (arith_done) ar_res <= arith_result;
			case (ex_state)
				fiqd_pkg::EX_IDLE: if (pop) begin
					ex_state <= fiqd_pkg::EX_RUN;
					ex_act <= d_act;
					ex_cnt <= fiqd_pkg::CYC_W'(d_cyc - 1'b1);
					ex_dst <= d_dst;
					ex_src <= stn;
					ex_pop <= d_pop;
					ex_ar <= d_arith;
					ex_got <= 1'b0;
					ex_op <= {hop, hm};
				end
				fiqd_pkg::EX_RUN: begin
					if (arith_done) ex_got <= 1'b1;
					if (ex_cnt != '0) ex_cnt <= ex_cnt - 1'b1;
					else if (ar_ok) ex_state <= fiqd_pkg::EX_IDLE;
				end
				default: ex_state <= fiqd_pkg::EX_IDLE;
			endcase
		end
	end

	// Request to the arithmetic datapath
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arith_start <= 1'b0;
			arith_kind <= fiqd_pkg::AR_FLOAT_ADD_OP;
			arith_fmt <= fiqd_pkg::FMT_NONE;
			arith_a <= 80'h0;
			arith_b <= 80'h0;
		end else begin
			arith_start <= pop && d_arith;
			if (pop && d_arith) begin
				arith_kind <= d_ar;
				arith_fmt <= is_reg ? fiqd_pkg::FMT_REAL80
					: fmt_of(hop, rf);
				arith_a <= st[top];
				arith_b <= is_reg ? st[stn] : q_mem[rd_ptr];
			end
		end
	end

	// Register stack; commit has priority over software loads
	always_ff @(posedge sys_clk) begin
		if (commit) begin
			case (ex_act)
				fiqd_pkg::ACT_ABS: st[ex_dst][fiqd_pkg::SIGN_BIT] <= 1'b0;
				fiqd_pkg::ACT_CHS: st[ex_dst][fiqd_pkg::SIGN_BIT] <=
					~st[ex_dst][fiqd_pkg::SIGN_BIT];
				fiqd_pkg::ACT_CMOV: st[ex_dst] <= st[ex_src];
				fiqd_pkg::ACT_ARITH: st[ex_dst] <= ar_val;
				default: ;
			endcase
		end else if (reg_wr && reg_addr == fiqd_pkg::REG_DLO) begin
			st[sel][31:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == fiqd_pkg::REG_DMID) begin
			st[sel][63:32] <= reg_wdata;
		end else if (reg_wr && reg_addr == fiqd_pkg::REG_DHI) begin
			st[sel][79:64] <= reg_wdata[15:0];
		end
	end

	// ----------------------------------------
	// Status, flags and register port
	// ----------------------------------------
	wire st_wr = reg_wr && reg_addr == fiqd_pkg::REG_STATUS;
	wire [5:0] exc_clr = (commit && ex_act == fiqd_pkg::ACT_CLR) ? 6'h3f
		: st_wr ? reg_wdata[fiqd_pkg::ST_EXC_LSB +: 6] : 6'h00;
	wire [31:0] status_w = (32'(exc) << fiqd_pkg::ST_EXC_LSB)
		| (32'(top) << fiqd_pkg::ST_TOP_LSB)
		| (32'(busy) << fiqd_pkg::ST_BUSY)
		| (32'(q_cnt) << fiqd_pkg::ST_CNT_LSB)
		| (32'(saved) << fiqd_pkg::ST_SAVED)
		| (32'(unsup) << fiqd_pkg::ST_UNSUP);
	wire [31:0] rd_mux = (reg_addr == fiqd_pkg::REG_STATUS) ? status_w
		: (reg_addr == fiqd_pkg::REG_SAVED) ? 32'(saved_word)
		: (reg_addr == fiqd_pkg::REG_SEL) ? 32'(sel)
		: (reg_addr == fiqd_pkg::REG_DLO) ? st[sel][31:0]
		: (reg_addr == fiqd_pkg::REG_DMID) ? st[sel][63:32]
		: (reg_addr == fiqd_pkg::REG_DHI) ? 32'(st[sel][79:64])
		: 32'h0000_0000;

	// Stack top, sticky flags and saved state; hardware set wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			top <= 3'h0;
			exc <= 6'h00;
			saved <= 1'b0;
			saved_word <= 19'h0_0000;
			unsup <= 1'b0;
			sel <= 3'h0;
			reg_rdata <= 32'h0000_0000;
		end else begin
			if (commit && ex_pop) top <= 3'(top + 1'b1);
			exc <= (exc & ~exc_clr) | (arith_done ? arith_exc : 6'h00);
			if (exc_evt && q_cnt != '0) begin
				saved <= 1'b1;
				saved_word <= {top, ex_op};
			end else if (st_wr && reg_wdata[fiqd_pkg::ST_SAVED]) begin
				saved <= 1'b0;
			end
			if (pop && !d_known) unsup <= 1'b1;
			else if (st_wr && reg_wdata[fiqd_pkg::ST_UNSUP]) unsup <= 1'b0;
			if (reg_wr && reg_addr == fiqd_pkg::REG_SEL) sel <= reg_wdata[2:0];
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

// >>> hdl/fiqd_pkg.sv
package fiqd_pkg;

	// ----------------------------------------
	// Timing counts, in FPU clocks
	// ----------------------------------------
	localparam int CYC_W        = 7;
	localparam int HANDOVER_CYC = 2;
	localparam int CYC_POW2_MIN = 92;
	localparam int CYC_POW2_MAX = 108;
	localparam int CYC_ABS      = 2;
	localparam int CYC_CHS      = 2;
	localparam int CYC_FLOAT_ADD_OP_MIN = 4;
	localparam int CYC_FLOAT_ADD_OP_MAX = 9;
	localparam int CYC_IADD_MIN = 8;
	localparam int CYC_IADD_MAX = 14;
	localparam int CYC_CLR_WAIT = 5;
	localparam int CYC_CLR_NOW  = 3;
	localparam int CYC_CMOV     = 4;
	localparam int CYC_UNSUP    = 1;

	// ----------------------------------------
	// Opcode bytes and fault vectors
	// ----------------------------------------
	localparam logic [7:0] OP_D8    = 8'hd8;
	localparam logic [7:0] OP_D9    = 8'hd9;
	localparam logic [7:0] OP_DA    = 8'hda;
	localparam logic [7:0] OP_DB    = 8'hdb;
	localparam logic [7:0] OP_DC    = 8'hdc;
	localparam logic [7:0] OP_DD    = 8'hdd;
	localparam logic [7:0] OP_DE    = 8'hde;
	localparam logic [7:0] OP_DF    = 8'hdf;
	localparam logic [7:0] MR_POW2  = 8'hf0;
	localparam logic [7:0] MR_ABS   = 8'he1;
	localparam logic [7:0] MR_CHS   = 8'he0;
	localparam logic [7:0] MR_CLEX  = 8'he2;
	localparam logic [7:0] FAULT_GP = 8'h0d;
	localparam logic [7:0] FAULT_SS = 8'h0c;
	localparam int         SIGN_BIT = 79;

	// ----------------------------------------
	// Register map and status fields
	// ----------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_SAVED  = 8'h04;
	localparam logic [7:0] REG_SEL    = 8'h08;
	localparam logic [7:0] REG_DLO    = 8'h0c;
	localparam logic [7:0] REG_DMID   = 8'h10;
	localparam logic [7:0] REG_DHI    = 8'h14;
	localparam int ST_EXC_LSB = 0;
	localparam int ST_TOP_LSB = 11;
	localparam int ST_BUSY    = 15;
	localparam int ST_CNT_LSB = 16;
	localparam int ST_SAVED   = 19;
	localparam int ST_UNSUP   = 20;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		FMT_INT16, FMT_INT32, FMT_INT64, FMT_REAL32,
		FMT_REAL64, FMT_REAL80, FMT_BCD, FMT_NONE
	} fiqd_fmt_t;
	typedef enum logic [2:0] {
		HS_IDLE = 3'h1, HS_DLY = 3'h2, HS_MEM = 3'h4
	} fiqd_hs_t;
	typedef enum logic [1:0] {
		EX_IDLE = 2'h1, EX_RUN = 2'h2
	} fiqd_ex_t;
	typedef enum logic [2:0] {
		ACT_NONE, ACT_ABS, ACT_CHS, ACT_CLR, ACT_CMOV, ACT_ARITH
	} fiqd_act_t;
	typedef enum logic [1:0] {
		AR_FLOAT_ADD_OP, AR_IADD, AR_POW2
	} fiqd_ar_t;

endpackage

// >>> tb/fiqd_chk.sv
`timescale 1ns/100ps
`default_nettype none

module fiqd_chk #(
	parameter int unsigned DEPTH = 4
) (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       iu_valid,
	input wire logic       iu_has_mem,
	input wire logic       prot_mode,
	input wire logic       seg_limit_viol,
	input wire logic       access_viol,
	input wire logic       stack_limit_viol,
	input wire logic       iu_ready,
	input wire logic       fault_valid,
	input wire logic [7:0] fault_vector,
	input wire logic       mem_req,
	input wire logic [2:0] mem_fmt,
	input wire logic       mem_valid,
	input wire logic       arith_start,
	input wire logic       reg_rd,
	input wire logic [31:0] reg_rdata
);
	logic bad;
	// Protected-mode operand violation present at the take
	assign bad = prot_mode && (seg_limit_viol || access_viol || stack_limit_viol);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence take_reg;
		iu_valid && iu_ready && !iu_has_mem;
	endsequence
	sequence take_flt;
		iu_valid && iu_ready && iu_has_mem && bad;
	endsequence
	sequence take_mem;
		iu_valid && iu_ready && iu_has_mem && !bad;
	endsequence

	handover_hold_a: assert property (take_reg |=> !iu_ready [*2])
		else $error("ready returned before the two-cycle hand-over");
	fault_pulse_a: assert property (take_flt |=> fault_valid ##1 !fault_valid)
		else $error("fault pulse missing or too long");
	fault_stack_a: assert property (take_flt ##0 (!seg_limit_viol && !access_viol)
		|=> fault_vector == fiqd_pkg::FAULT_SS)
		else $error("stack violation gave wrong vector");
	fault_prot_a: assert property (take_flt ##0 (seg_limit_viol || access_viol)
		|=> fault_vector == fiqd_pkg::FAULT_GP)
		else $error("segment violation gave wrong vector");
	fault_quiet_a: assert property (take_flt |=> !mem_req [*2])
		else $error("faulting operand was fetched");
	mem_fetch_a: assert property (take_mem |=> mem_req && !fault_valid)
		else $error("operand fetch not started");
	mem_hold_a: assert property (mem_req && !mem_valid |=> mem_req && $stable(mem_fmt))
		else $error("fetch request dropped or format changed");
	mem_stall_a: assert property (mem_req |-> !iu_ready)
		else $error("ready high while operand pending");
	start_once_a: assert property (arith_start |=> !arith_start)
		else $error("arith start longer than one cycle");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside read answer");
endmodule

bind fiqd_core fiqd_chk #(.DEPTH(DEPTH)) chk (.sys_clk, .rst_n, .iu_valid, .iu_has_mem,
	.prot_mode, .seg_limit_viol, .access_viol, .stack_limit_viol, .iu_ready,
	.fault_valid, .fault_vector, .mem_req, .mem_fmt, .mem_valid, .arith_start,
	.reg_rd, .reg_rdata);
`default_nettype wire

// >>> tb/fiqd_far.sv
`timescale 1ns/100ps
`default_nettype none

module fiqd_far (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        mem_req,
	input  wire logic        arith_start,
	input  wire logic [79:0] arith_a,
	input  wire logic [79:0] arith_b,
	input  wire logic        exc_inject,
	input  wire logic        slow,
	output var  logic        mem_valid,
	output var  logic [79:0] mem_data,
	output var  logic        arith_done,
	output var  logic [79:0] arith_result,
	output var  logic [5:0]  arith_exc
);
	logic [2:0] mc;
	logic [2:0] ac;
	logic       busy;
	// Operand fetch and arithmetic answer, prompt or slow
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mc <= 3'h0;
			ac <= 3'h0;
			busy <= 1'b0;
			mem_valid <= 1'b0;
			arith_done <= 1'b0;
			mem_data <= '0;
			arith_result <= '0;
			arith_exc <= 6'h00;
		end else begin
			mem_valid <= 1'b0;
			arith_done <= 1'b0;
			arith_exc <= 6'h00;
			mem_data <= ~mem_data;          // Stale data flips every cycle
			arith_result <= ~arith_result;
			mc <= (mem_req && !mem_valid) ? mc + 3'h1 : 3'h0;
			if (mem_req && !mem_valid && mc == (slow ? 3'h5 : 3'h1)) begin
				mem_valid <= 1'b1;
				mem_data <= 80'h3fff_8000_0000_0000_0000;
			end
			if (arith_start) begin
				busy <= 1'b1;
				ac <= 3'h0;
			end else if (busy) begin
				ac <= ac + 3'h1;
				if (ac == (slow ? 3'h6 : 3'h2)) begin
					busy <= 1'b0;
					arith_done <= 1'b1;
					arith_result <= arith_a + arith_b;
					arith_exc <= exc_inject ? 6'h01 : 6'h00;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/fpu_issue_queue_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none

module fpu_issue_queue_decoder_test;
	logic        sys_clk, rst_n, iu_valid, iu_wait_prefix, iu_has_mem;
	logic        iu_cf, iu_zf, iu_pf, prot_mode, seg_limit_viol;
	logic        access_viol, stack_limit_viol, iu_ready, fault_valid;
	logic        mem_req, mem_valid, arith_start, arith_done;
	logic        reg_wr, reg_rd, exc_inject, slow;
	logic [7:0]  iu_op, iu_modrm, fault_vector, reg_addr;
	logic [2:0]  mem_fmt, arith_fmt, tp, n, fl;
	logic [1:0]  arith_kind;
	logic [5:0]  arith_exc;
	logic [79:0] mem_data, arith_a, arith_b, arith_result, va, vb, got;
	logic [31:0] reg_wdata, reg_rdata, rd;
	int          errors, samples_checked, seed, k;
	logic [7:0]  mop [4];
	logic [2:0]  mfm [4];

	fiqd_core #(.DEPTH(4)) uut (.sys_clk, .rst_n, .iu_valid, .iu_op, .iu_modrm,
		.iu_wait_prefix, .iu_has_mem, .iu_cf, .iu_zf, .iu_pf, .prot_mode,
		.seg_limit_viol, .access_viol, .stack_limit_viol, .iu_ready, .fault_valid,
		.fault_vector, .mem_req, .mem_fmt, .mem_valid, .mem_data, .arith_start,
		.arith_kind, .arith_fmt, .arith_a, .arith_b, .arith_done, .arith_result,
		.arith_exc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	fiqd_far far (.sys_clk, .rst_n, .mem_req, .arith_start, .arith_a, .arith_b,
		.exc_inject, .slow, .mem_valid, .mem_data, .arith_done, .arith_result,
		.arith_exc);

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task chk(input string nm, input logic [79:0] e, input logic [79:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task print_verdict;
		$display("mismatches %0d of %0d checks", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	task ld(input logic [2:0] p, input logic [79:0] v);
		wr(fiqd_pkg::REG_SEL, {29'h0000_0000, p});
		wr(fiqd_pkg::REG_DLO, v[31:0]);
		wr(fiqd_pkg::REG_DMID, v[63:32]);
		wr(fiqd_pkg::REG_DHI, {16'h0000, v[79:64]});
	endtask
	task rd80(input logic [2:0] p);
		wr(fiqd_pkg::REG_SEL, {29'h0000_0000, p});
		rdr(fiqd_pkg::REG_DLO);
		got[31:0] = rd;
		rdr(fiqd_pkg::REG_DMID);
		got[63:32] = rd;
		rdr(fiqd_pkg::REG_DHI);
		got[79:64] = rd[15:0];
	endtask
	task offer(input logic [7:0] op, input logic [7:0] md, input logic w, input logic m);
		int t;
		@(posedge sys_clk);
		iu_op <= op;
		iu_modrm <= md;
		iu_wait_prefix <= w;
		iu_has_mem <= m;
		iu_valid <= 1'b1;
		t = 0;
		do begin
			@(posedge sys_clk);
			t++;
		end while (iu_ready !== 1'b1 && t < 800);
		iu_valid <= 1'b0;
		if (t >= 800) errors++;
	endtask
	// Wait until queue empty and nothing executing
	task settle;
		repeat (3) @(posedge sys_clk);
		k = 0;
		do begin
			rdr(fiqd_pkg::REG_STATUS);
			k++;
		end while ((rd[15] !== 1'b0 || rd[18:16] !== 3'h0) && k < 1000);
		if (k >= 1000) errors++;
		tp = rd[fiqd_pkg::ST_TOP_LSB +: 3];
	endtask
	task wait_on(input int which);
		k = 0;
		while ((which ? arith_start : mem_req) !== 1'b1 && k < 300) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 300) errors++;
		#1;
	endtask
	// Conditional move outcome from the flags {cf, zf, pf}
	function automatic logic cm(input logic [2:0] s, input logic [2:0] f);
		case (s)
			3'h0: return f[2];
			3'h1: return f[1];
			3'h2: return f[2] | f[1];
			3'h3: return f[0];
			3'h4: return !f[2];
			3'h5: return !f[1];
			3'h6: return !f[2] && !f[1];
			default: return !f[0];
		endcase
	endfunction

	// Watchdog
	initial begin
		#2000000;
		errors++;
		print_verdict();
	end

	// Main sequence
	initial begin
		{iu_valid, iu_wait_prefix, iu_has_mem, iu_cf, iu_zf, iu_pf} = 6'h00;
		{prot_mode, seg_limit_viol, access_viol, stack_limit_viol} = 4'h0;
		{reg_wr, reg_rd, exc_inject, slow, rst_n} = 5'h00;
		{iu_op, iu_modrm, reg_addr, reg_wdata} = 56'h0;
		{errors, samples_checked} = 64'h0;
		seed = 32'h8f3c_460e;
		mop = '{fiqd_pkg::OP_DC, fiqd_pkg::OP_D8, fiqd_pkg::OP_DA, fiqd_pkg::OP_DE};
		mfm = '{fiqd_pkg::FMT_REAL64, fiqd_pkg::FMT_REAL32, fiqd_pkg::FMT_INT32,
			fiqd_pkg::FMT_INT16};
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdr(fiqd_pkg::REG_STATUS);
		chk("status", 80'h0, rd & 32'h001f_803f);
		rdr(8'h40);
		chk("unmapped", 80'h0, rd);
		settle();
		va = {$random(seed), $random(seed), $random(seed)} >> 16;
		ld(3'h5, va);
		rd80(3'h5);
		chk("stack_pair", va, got);
		for (int j = 0; j < 4; j++) begin
			va = {$random(seed), $random(seed), $random(seed)} >> 16;
			ld(tp, va);
			offer(fiqd_pkg::OP_D9, j[0] ? fiqd_pkg::MR_CHS : fiqd_pkg::MR_ABS, 1'b0, 1'b0);
			settle();
			rd80(tp);
			chk("abs_chs", j[0] ? {~va[79], va[78:0]} : {1'b0, va[78:0]}, got);
		end
		for (int i = 0; i < 16; i++) begin
			n = 3'(i % 7 + 1);
			fl = 3'($random(seed));
			va = {$random(seed), $random(seed), $random(seed)} >> 16;
			vb = ~va;
			ld(tp, va);
			ld(tp + n, vb);
			{iu_cf, iu_zf, iu_pf} <= fl;
			offer(i[2] ? fiqd_pkg::OP_DB : fiqd_pkg::OP_DA, {3'h6, i[1:0], n}, 1'b0, 1'b0);
			settle();
			rd80(tp);
			chk("cmov", cm(i[2:0], fl) ? vb : va, got);
		end
		for (int f = 0; f < 3; f++) begin
			n = 3'($random(seed)) | 3'h1;
			va = {$random(seed), $random(seed), $random(seed)} >> 16;
			vb = {$random(seed), $random(seed), $random(seed)} >> 16;
			ld(tp, va);
			ld(tp + n, vb);
			slow <= f[0];
			fl = tp;
			offer(f == 0 ? fiqd_pkg::OP_D8 : mop[f == 1 ? 0 : 3], {5'h18, n}, 1'b0, 1'b0);
			wait_on(1);
			chk("float_add_op_kind", 80'h0, arith_kind);
			chk("float_add_op_a", va, arith_a);
			chk("float_add_op_b", vb, arith_b);
			chk("float_add_op_fmt", 80'(fiqd_pkg::FMT_REAL80), arith_fmt);
			settle();
			rd80(f == 0 ? tp : (f == 2 ? tp - 3'h1 + n : tp + n));
			chk("float_add_op_sum", va + vb, got);
			chk("pop_top", 80'(f == 2 ? 3'(fl + 3'h1) : fl), 80'(tp));
		end
		for (int j = 0; j < 4; j++) begin
			slow <= j[0];
			offer(mop[j], 8'h00, 1'b0, 1'b1);
			wait_on(0);
			chk("mem_fmt", 80'(mfm[j]), mem_fmt);
			wait_on(1);
			chk("mem_kind", j < 2 ? 80'h0 : 80'h1, arith_kind);
			chk("mem_afmt", 80'(mfm[j]), arith_fmt);
			chk("mem_b", 80'h3fff_8000_0000_0000_0000, arith_b);
			settle();
		end
		prot_mode <= 1'b1;
		for (int v = 1; v < 8; v++) begin
			{seg_limit_viol, access_viol, stack_limit_viol} <= 3'(v);
			offer(fiqd_pkg::OP_DC, 8'h00, 1'b0, 1'b1);
			@(posedge sys_clk);
			chk("fault_valid", 80'h1, fault_valid);
			chk("fault_vec", v == 1 ? 80'h0c : 80'h0d, fault_vector);
		end
		prot_mode <= 1'b0;
		offer(fiqd_pkg::OP_D8, 8'h00, 1'b0, 1'b1);
		wait_on(0);
		chk("real_mode_fetch", 80'h1, mem_req);
		{seg_limit_viol, access_viol, stack_limit_viol} <= 3'h0;
		settle();
		exc_inject <= 1'b1;
		for (int j = 0; j < 5; j++)
			offer(fiqd_pkg::OP_D9, fiqd_pkg::MR_POW2, 1'b0, 1'b0);
		repeat (3) @(posedge sys_clk);
		chk("queue_full_ready", 80'h0, iu_ready);
		rdr(fiqd_pkg::REG_STATUS);
		chk("queue_count", 80'h4, rd[18:16]);
		wait_on(1);
		chk("pow2_kind", 80'h2, arith_kind);
		settle();
		exc_inject <= 1'b0;
		chk("saved_flag", 80'h1, rd[fiqd_pkg::ST_SAVED]);
		rdr(fiqd_pkg::REG_SAVED);
		chk("saved_op", 80'hd9f0, rd[15:0]);
		for (int w = 0; w < 2; w++) begin
			exc_inject <= 1'b1;
			offer(fiqd_pkg::OP_D8, 8'hc1, 1'b0, 1'b0);
			settle();
			exc_inject <= 1'b0;
			chk("exc_set", 80'h01, rd[5:0]);
			offer(fiqd_pkg::OP_DB, fiqd_pkg::MR_CLEX, w[0], 1'b0);
			settle();
			chk("exc_clear", 80'h00, rd[5:0]);
		end
		offer(fiqd_pkg::OP_DD, 8'hc0, 1'b0, 1'b0);
		settle();
		chk("unsup_flag", 80'h1, rd[fiqd_pkg::ST_UNSUP]);
		print_verdict();
	end
endmodule
`default_nettype wire
